// >>> mcal_top.sv
// Operation
// - Aux unit code 0,1,3,4 selects unused, bias, cooler current, temperature format.
// - Aux codes 6..9 are supply voltages in primary voltage format.
// - Aux codes A and D..F are supply currents, 0.1 mA steps.
// - Every channel result is compared with thresholds and sets warning or alarm flags.
// - Unmasked flags of alerting channels raise the host alert output.
// - Monitor diode or bias excursion trips safety fault, gate on, currents off.
// - Receive power and bias sense carry 38.147 nV per count when factory set.
// - Supply and aux voltage results are unsigned 16-bit, 100 uV per count.
// - Temperature is signed 16-bit, whole degrees high, 1/256 degree low.
// - Unsigned channels have gain and offset; temperature and signed aux have offset only.
// - Right shift exists for bias, receive, unsigned aux and monitor diode only.
// - Calibrated null gives zero, one step below full scale gives the FFF8h ceiling.
// - Results are 16 bits; full scale is 65536 counts.
// - Unsigned channel ceiling is FFF8h shifted right by the shift count where shift exists; signed results clip at 7FFFh.
// - Eight conversions averaged per result, sixteen for temperature, 13 bits.
// - Non-zero shift moves calibrated result right just before storing.
// - Flags latch on first excursion and clear when the host reads them.
`timescale 1ns/1ps
module mcal_top #(
  parameter int NUM_CH = mcal_pkg::NUM_CH
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_conv_valid,
  input wire logic [2:0] i_conv_chan,
  input wire logic [15:0] i_conv_data,
  input wire logic [NUM_CH-1:0][15:0] i_gain,
  input wire logic [NUM_CH-1:0][15:0] i_offset,
  input wire logic [NUM_CH-1:0][3:0] i_shift,
  input wire logic [3:0] i_aux1_unit,
  input wire logic [3:0] i_aux2_unit,
  input wire logic [NUM_CH-1:0][15:0] i_thr_high_alarm,
  input wire logic [NUM_CH-1:0][15:0] i_thr_high_warn,
  input wire logic [NUM_CH-1:0][15:0] i_thr_low_warn,
  input wire logic [NUM_CH-1:0][15:0] i_thr_low_alarm,
  input wire logic [NUM_CH-1:0][3:0] i_flag_mask,
  input wire logic i_flag_read,
  input wire logic [2:0] i_flag_read_chan,
  input wire logic [15:0] i_trip_md_high,
  input wire logic [15:0] i_trip_md_low,
  input wire logic [15:0] i_trip_bias_high,
  input wire logic [2:0] i_trip_mask,
  input wire logic i_fault_clear,
  output logic [NUM_CH-1:0][15:0] o_result,
  output logic o_result_valid,
  output logic [2:0] o_result_chan,
  output logic [NUM_CH-1:0][3:0] o_flags,
  output logic o_alert,
  output logic [2:0] o_trip_flags,
  output logic o_laser_gate_output,
  output logic o_bias_current_output_en,
  output logic o_modulation_current_output_en,
  output logic [1:0] o_aux1_format,
  output logic [1:0] o_aux2_format
);

  function automatic mcal_pkg::mcal_fmt_t unit_fmt(input logic [3:0] code);
    if (code == mcal_pkg::UNIT_UNUSED) begin
      unit_fmt = mcal_pkg::MCAL_FMT_UNUSED;
    end else if (code == mcal_pkg::UNIT_LASER_TEMP) begin
      unit_fmt = mcal_pkg::MCAL_FMT_SIGNED;
    end else if ((code == mcal_pkg::UNIT_PD_BIAS) || (code == mcal_pkg::UNIT_COOLER_I)) begin
      unit_fmt = mcal_pkg::MCAL_FMT_UNSIGNED;
    end else if ((code >= mcal_pkg::UNIT_SUP_V_FIRST) &&
                 (code <= mcal_pkg::UNIT_SUP_V_LAST)) begin
      unit_fmt = mcal_pkg::MCAL_FMT_UNSIGNED;
    end else if ((code == mcal_pkg::UNIT_SUP_I_FIRST) ||
                 (code >= mcal_pkg::UNIT_SUP_I_LO)) begin
      unit_fmt = mcal_pkg::MCAL_FMT_UNSIGNED;
    end else begin
      // Reserved codes read unsigned
      unit_fmt = mcal_pkg::MCAL_FMT_UNSIGNED;
    end
  endfunction : unit_fmt

  // Per-channel result format
  function automatic mcal_pkg::mcal_fmt_t chan_fmt(input logic [2:0] ch,
                                                   input logic [3:0] u1,
                                                   input logic [3:0] u2);
    case (ch)
      mcal_pkg::CH_TEMP: chan_fmt = mcal_pkg::MCAL_FMT_SIGNED;
      mcal_pkg::CH_AUX1: chan_fmt = unit_fmt(u1);
      mcal_pkg::CH_AUX2: chan_fmt = unit_fmt(u2);
      default: chan_fmt = mcal_pkg::MCAL_FMT_UNSIGNED;
    endcase
  endfunction : chan_fmt

  // Threshold compare, signed or unsigned
  function automatic logic above(input logic [15:0] a, input logic [15:0] b,
                                 input logic sgn);
    above = sgn ? (signed'(a) > signed'(b)) : (a > b);
  endfunction : above

  logic [NUM_CH-1:0][mcal_pkg::ACC_W-1:0] acc;
  logic [NUM_CH-1:0][mcal_pkg::ACC_W-1:0] next_acc;
  logic [NUM_CH-1:0][4:0] cnt;
  logic [NUM_CH-1:0][4:0] next_cnt;
  logic avg_valid;
  logic next_avg_valid;
  logic [2:0] avg_chan;
  logic [2:0] next_avg_chan;
  logic [15:0] avg;
  logic [15:0] next_avg;
  logic [NUM_CH-1:0][15:0] next_result;
  logic next_result_valid;
  logic [2:0] next_result_chan;
  logic [NUM_CH-1:0][3:0] next_flags;
  logic [2:0] next_trip_flags;
  logic fault;
  logic next_fault;
  logic [15:0] cal_out;
  logic avg_signed;
  logic next_alert;

  mcal_pkg::mcal_fmt_t conv_fmt;
  mcal_pkg::mcal_fmt_t res_fmt;

  assign conv_fmt = chan_fmt(i_conv_chan, i_aux1_unit, i_aux2_unit);
  assign res_fmt = chan_fmt(o_result_chan, i_aux1_unit, i_aux2_unit);
  assign avg_signed = (chan_fmt(avg_chan, i_aux1_unit, i_aux2_unit) == mcal_pkg::MCAL_FMT_SIGNED);
  assign o_aux1_format = unit_fmt(i_aux1_unit);
  assign o_aux2_format = unit_fmt(i_aux2_unit);

  // Averaging of raw conversions
  always_comb begin
    logic [mcal_pkg::ACC_W-1:0] ext;
    logic [mcal_pkg::ACC_W-1:0] tot;
    logic [4:0] len;
    ext = '0;
    tot = '0;
    len = mcal_pkg::AVG_LEN;
    next_acc = acc;
    next_cnt = cnt;
    next_avg_valid = 1'b0;
    next_avg_chan = avg_chan;
    next_avg = avg;
    if (i_conv_valid && (32'(i_conv_chan) < NUM_CH) &&
        (conv_fmt != mcal_pkg::MCAL_FMT_UNUSED)) begin
      if (conv_fmt == mcal_pkg::MCAL_FMT_SIGNED) begin
        ext = {{(mcal_pkg::ACC_W-16){i_conv_data[15]}}, i_conv_data};
      end else begin
        ext = {{(mcal_pkg::ACC_W-16){1'b0}}, i_conv_data};
      end
      // Per-channel running sum
      tot = acc[i_conv_chan] + ext;
      if (i_conv_chan == mcal_pkg::CH_TEMP) begin
        len = mcal_pkg::AVG_LEN_TEMP;
      end
      if (cnt[i_conv_chan] == len - 5'h01) begin
        next_acc[i_conv_chan] = '0;
        next_cnt[i_conv_chan] = 5'h00;
        next_avg_valid = 1'b1;
        next_avg_chan = i_conv_chan;
        if (i_conv_chan == mcal_pkg::CH_TEMP) begin
          next_avg = tot[mcal_pkg::AVG_SH_TEMP +: 16];
        end else begin
          next_avg = tot[mcal_pkg::AVG_SH +: 16];
        end
      end else begin
        next_acc[i_conv_chan] = tot;
        next_cnt[i_conv_chan] = cnt[i_conv_chan] + 5'h01;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc <= '0;
      cnt <= '0;
      avg_valid <= 1'b0;
      avg_chan <= 3'h0;
      avg <= 16'h0000;
    end else begin
      acc <= next_acc;
      cnt <= next_cnt;
      avg_valid <= next_avg_valid;
      avg_chan <= next_avg_chan;
      avg <= next_avg;
    end
  end

  mcal_calib u_calib (
    .i_avg(avg),
    .i_gain(i_gain[avg_chan]),
    .i_offset(i_offset[avg_chan]),
    .i_shift(i_shift[avg_chan]),
    .i_gain_en(mcal_pkg::GAIN_CH[avg_chan]),
    .i_shift_en(mcal_pkg::SHIFT_CH[avg_chan]),
    .i_signed(avg_signed),
    .o_result(cal_out)
  );

  always_comb begin
    // Hold results between stores
    next_result = o_result;
    next_result_valid = avg_valid;
    next_result_chan = o_result_chan;
    if (avg_valid) begin
      next_result[avg_chan] = cal_out;
      next_result_chan = avg_chan;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_result <= '0;
      o_result_valid <= 1'b0;
      o_result_chan <= 3'h0;
    end else begin
      o_result <= next_result;
      o_result_valid <= next_result_valid;
      o_result_chan <= next_result_chan;
    end
  end

  always_comb begin
    logic [15:0] r;
    logic sgn;
    logic [3:0] hit;
    r = o_result[o_result_chan];
    sgn = (res_fmt == mcal_pkg::MCAL_FMT_SIGNED);
    hit = '0;
    hit[mcal_pkg::FL_HIGH_ALARM] = above(r, i_thr_high_alarm[o_result_chan], sgn);
    hit[mcal_pkg::FL_HIGH_WARN] = above(r, i_thr_high_warn[o_result_chan], sgn);
    hit[mcal_pkg::FL_LOW_WARN] = above(i_thr_low_warn[o_result_chan], r, sgn);
    hit[mcal_pkg::FL_LOW_ALARM] = above(i_thr_low_alarm[o_result_chan], r, sgn);
    // Clear first so a set wins
    next_flags = o_flags;
    if (i_flag_read && (32'(i_flag_read_chan) < NUM_CH)) begin
      next_flags[i_flag_read_chan] = 4'h0;
    end
    if (o_result_valid) begin
      next_flags[o_result_chan] = next_flags[o_result_chan] |
                                  (hit & ~i_flag_mask[o_result_chan]);
    end
  end

  always_comb begin
    logic [2:0] trip;
    trip = '0;
    if (o_result_valid && (o_result_chan == mcal_pkg::CH_MD)) begin
      trip[mcal_pkg::TR_MD_HIGH] = o_result[mcal_pkg::CH_MD] > i_trip_md_high;
      trip[mcal_pkg::TR_MD_LOW] = o_result[mcal_pkg::CH_MD] < i_trip_md_low;
    end
    if (o_result_valid && (o_result_chan == mcal_pkg::CH_BIAS)) begin
      trip[mcal_pkg::TR_BIAS_HIGH] = o_result[mcal_pkg::CH_BIAS] > i_trip_bias_high;
    end
    trip = trip & ~i_trip_mask;
    next_trip_flags = i_fault_clear ? 3'h0 : o_trip_flags;
    next_trip_flags = next_trip_flags | trip;
    // Trip wins over clear
    next_fault = (fault && !i_fault_clear) || (trip != 3'h0);
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flags <= '0;
      o_alert <= 1'b0;
      o_trip_flags <= 3'h0;
      fault <= 1'b0;
    end else begin
      o_flags <= next_flags;
      o_alert <= next_alert;
      o_trip_flags <= next_trip_flags;
      fault <= next_fault;
    end
  end

  always_comb begin
    next_alert = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (mcal_pkg::ALERT_CH[c] && (next_flags[c] != 4'h0)) begin
        next_alert = 1'b1;
      end
    end
  end

  assign o_laser_gate_output = fault;
  assign o_bias_current_output_en = !fault;
  assign o_modulation_current_output_en = !fault;

endmodule : mcal_top

// >>> mcal_pkg.sv
package mcal_pkg;
  // Channel count and indices
  localparam int NUM_CH = 7;
  localparam int CH_W = 3;
  localparam logic [2:0] CH_TEMP = 3'h0;
  localparam logic [2:0] CH_SUPPLY = 3'h1;
  localparam logic [2:0] CH_BIAS = 3'h2;
  localparam logic [2:0] CH_RX = 3'h3;
  localparam logic [2:0] CH_AUX1 = 3'h4;
  localparam logic [2:0] CH_AUX2 = 3'h5;
  localparam logic [2:0] CH_MD = 3'h6;

  // Result layout and weights
  localparam int RES_W = 16;
  localparam int SIG_BITS = 13;
  localparam int RX_BIAS_LSB_PV = 38147;
  localparam int SUPPLY_LSB_UV = 100;
  localparam int TEMP_FRAC_DIV = 256;
  localparam logic [15:0] RES_CEIL = 16'hFFF8;
  localparam logic [15:0] SIGNED_MAX = 16'h7FFF;
  localparam logic [15:0] SIGNED_MIN = 16'h8000;

  // Calibration arithmetic
  localparam int GAIN_FRAC = 15;
  localparam int OFFSET_SCALE = 2;
  localparam int SHIFT_W = 4;

  // Averaging
  localparam int ACC_W = 20;
  localparam logic [4:0] AVG_LEN = 5'h08;
  localparam logic [4:0] AVG_LEN_TEMP = 5'h10;
  localparam int AVG_SH = 3;
  localparam int AVG_SH_TEMP = 4;

  // Which channels have gain, right shift and alert
  localparam logic [6:0] GAIN_CH = 7'h7E;
  localparam logic [6:0] SHIFT_CH = 7'h7C;
  localparam logic [6:0] ALERT_CH = 7'h3F;

  // Auxiliary unit codes
  localparam logic [3:0] UNIT_UNUSED = 4'h0;
  localparam logic [3:0] UNIT_PD_BIAS = 4'h1;
  localparam logic [3:0] UNIT_COOLER_I = 4'h3;
  localparam logic [3:0] UNIT_LASER_TEMP = 4'h4;
  localparam logic [3:0] UNIT_SUP_V_FIRST = 4'h6;
  localparam logic [3:0] UNIT_SUP_V_LAST = 4'h9;
  localparam logic [3:0] UNIT_SUP_I_FIRST = 4'hA;
  localparam logic [3:0] UNIT_SUP_I_LO = 4'hD;
  localparam logic [3:0] UNIT_SUP_I_LAST = 4'hF;

  typedef enum logic [1:0] {
    MCAL_FMT_UNUSED = 2'h0,
    MCAL_FMT_UNSIGNED = 2'h1,
    MCAL_FMT_SIGNED = 2'h2
  } mcal_fmt_t;

  // Flag positions
  localparam int FLAG_W = 4;
  localparam int FL_LOW_ALARM = 0;
  localparam int FL_LOW_WARN = 1;
  localparam int FL_HIGH_WARN = 2;
  localparam int FL_HIGH_ALARM = 3;

  // Safety trip positions
  localparam int TRIP_W = 3;
  localparam int TR_MD_LOW = 0;
  localparam int TR_MD_HIGH = 1;
  localparam int TR_BIAS_HIGH = 2;
endpackage : mcal_pkg

// >>> mcal_calib.sv
`timescale 1ns/1ps
module mcal_calib (
  input wire logic [15:0] i_avg,
  input wire logic [15:0] i_gain,
  input wire logic [15:0] i_offset,
  input wire logic [3:0] i_shift,
  input wire logic i_gain_en,
  input wire logic i_shift_en,
  input wire logic i_signed,
  output logic [15:0] o_result
);
  logic [31:0] prod;
  logic [16:0] scaled;
  logic signed [18:0] base;
  logic signed [18:0] offs;
  logic signed [18:0] sum;
  logic [15:0] sat;
  logic [3:0] sh;

  always_comb begin
    prod = 32'(i_avg) * 32'(i_gain);
    // Gain first
    scaled = i_gain_en ? prod[31:mcal_pkg::GAIN_FRAC] : {1'b0, i_avg};
    base = i_signed ? 19'(signed'(i_avg)) : signed'({2'h0, scaled});
    // Offset added in steps of four counts
    offs = signed'({i_offset[15], i_offset, 2'h0});
    sum = base + offs;
    sh = i_shift_en ? i_shift : 4'h0;
    if (i_signed) begin
      if (sum > 19'(signed'(mcal_pkg::SIGNED_MAX))) begin
        sat = mcal_pkg::SIGNED_MAX;
      end else if (sum < 19'(signed'(mcal_pkg::SIGNED_MIN))) begin
        sat = mcal_pkg::SIGNED_MIN;
      end else begin
        sat = sum[15:0];
      end
    end else if (sum < 19'sh0) begin
      sat = 16'h0000;
    end else if (sum > signed'({3'h0, mcal_pkg::RES_CEIL})) begin
      sat = mcal_pkg::RES_CEIL;
    end else begin
      sat = sum[15:0];
    end
    // Shift last, ceiling follows
    o_result = i_signed ? sat : (sat >> sh);
  end
endmodule : mcal_calib

// >>> mcal_top_chk.sv
`timescale 1ns/1ps
module mcal_top_chk #(
  parameter int NUM_CH = mcal_pkg::NUM_CH
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_conv_valid,
  input wire logic [3:0] i_aux1_unit,
  input wire logic i_flag_read,
  input wire logic [2:0] i_flag_read_chan,
  input wire logic i_fault_clear,
  input wire logic o_result_valid,
  input wire logic [2:0] o_result_chan,
  input wire logic [NUM_CH-1:0][3:0] o_flags,
  input wire logic o_alert,
  input wire logic [2:0] o_trip_flags,
  input wire logic o_laser_gate_output,
  input wire logic o_bias_current_output_en,
  input wire logic o_modulation_current_output_en,
  input wire logic [1:0] o_aux1_format
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence s_stored;
    o_result_valid;
  endsequence
  sequence s_clear;
    i_fault_clear && !o_result_valid;
  endsequence
  AST_FMT: assert property (o_aux1_format == ((i_aux1_unit == 4'h0) ? 2'h0 :
    (i_aux1_unit == 4'h4) ? 2'h2 : 2'h1)) else $error("aux format decode wrong");
  AST_VALID_SRC: assert property (s_stored |-> $past(i_conv_valid, 2))
    else $error("result without a sample taken");
  AST_FLAG_CAUSE: assert property ((o_flags & ~$past(o_flags)) != '0
    |-> $past(o_result_valid)) else $error("flag rose without a stored result");
  AST_FLAG_LATCH: assert property (!i_flag_read
    |=> (o_flags & $past(o_flags)) == $past(o_flags)) else $error("flag fell without a read");
  AST_FLAG_CLR: assert property (i_flag_read && i_flag_read_chan != 3'h7 && !o_result_valid
    |=> o_flags[$past(i_flag_read_chan)] == 4'h0) else $error("read did not clear flags");
  AST_ALERT: assert property (o_alert == (|o_flags[5:0]))
    else $error("alert does not follow flags");
  AST_GATE_CURR: assert property (o_bias_current_output_en == !o_laser_gate_output
    && o_modulation_current_output_en == !o_laser_gate_output) else $error("currents not off");
  AST_GATE_CAUSE: assert property ($rose(o_laser_gate_output) |-> $past(o_result_valid)
    && $past(o_result_chan) inside {3'h2, 3'h6}) else $error("gate without trip result");
  AST_GATE_HOLD: assert property (o_laser_gate_output && !i_fault_clear
    |=> o_laser_gate_output) else $error("gate dropped without clear");
  AST_FAULT_CLR: assert property (s_clear
    |=> !o_laser_gate_output && o_trip_flags == 3'h0) else $error("fault clear ignored");
endmodule : mcal_top_chk
bind mcal_top mcal_top_chk #(.NUM_CH(NUM_CH)) mcal_top_chk_inst (.i_mclk(i_mclk),
  .i_nrst(i_nrst), .i_conv_valid(i_conv_valid), .i_aux1_unit(i_aux1_unit),
  .i_flag_read(i_flag_read), .i_flag_read_chan(i_flag_read_chan),
  .i_fault_clear(i_fault_clear), .o_result_valid(o_result_valid),
  .o_result_chan(o_result_chan), .o_flags(o_flags), .o_alert(o_alert),
  .o_trip_flags(o_trip_flags), .o_laser_gate_output(o_laser_gate_output),
  .o_bias_current_output_en(o_bias_current_output_en),
  .o_modulation_current_output_en(o_modulation_current_output_en),
  .o_aux1_format(o_aux1_format));

// >>> mcal_src.sv
`timescale 1ns/1ps
module mcal_src (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [2:0] i_chan,
  input wire logic [15:0] i_data,
  input wire logic [4:0] i_count,
  input wire logic i_slow,
  output logic o_conv_valid,
  output logic [2:0] o_conv_chan,
  output logic [15:0] o_conv_data
);
  logic [4:0] left = 5'h00;
  logic gap = 1'b0;
  initial begin
    o_conv_valid = 1'b0;
    o_conv_chan = 3'h7;
    o_conv_data = 16'h0000;
  end
  always @(posedge i_mclk) begin
    if (i_go) begin
      left <= i_count;
      gap <= i_slow;
      o_conv_valid <= 1'b0;
    end else if (left != 5'h00 && !gap) begin
      o_conv_valid <= 1'b1;
      o_conv_chan <= i_chan;
      o_conv_data <= i_data;
      left <= left - 5'h01;
      gap <= i_slow;
    end else begin
      o_conv_valid <= 1'b0;
      o_conv_chan <= ~o_conv_chan;
      o_conv_data <= ~o_conv_data;
      gap <= 1'b0;
    end
  end
endmodule : mcal_src

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int N = mcal_pkg::NUM_CH;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [2:0] s_chan = 3'h0;
  logic [15:0] s_data = 16'h0000;
  logic [4:0] s_cnt = 5'h00;
  logic cv;
  logic [2:0] cc;
  logic [15:0] cd;
  logic [N-1:0][15:0] gain, offset, thr_ha, thr_hw, thr_lw, thr_la, result;
  logic [N-1:0][3:0] shift, mask, flags;
  logic [3:0] aux_unit = 4'h1;
  logic rd = 1'b0;
  logic [2:0] rd_chan = 3'h0;
  logic [15:0] tmd_hi = 16'hFFFF;
  logic [2:0] tmask = 3'h0;
  logic fclr = 1'b0;
  logic r_valid, alert, gate, bias_en, mod_en;
  logic [2:0] r_chan, trips;
  logic [1:0] fmt1, fmt2;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  always #25 i_mclk = ~i_mclk;
  mcal_src mcal_src_inst (.i_mclk(i_mclk), .i_go(go), .i_chan(s_chan), .i_data(s_data),
    .i_count(s_cnt), .i_slow(slow), .o_conv_valid(cv), .o_conv_chan(cc), .o_conv_data(cd));
  mcal_top mcal_top_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_conv_valid(cv),
    .i_conv_chan(cc), .i_conv_data(cd), .i_gain(gain), .i_offset(offset), .i_shift(shift),
    .i_aux1_unit(aux_unit), .i_aux2_unit(aux_unit), .i_thr_high_alarm(thr_ha),
    .i_thr_high_warn(thr_hw), .i_thr_low_warn(thr_lw), .i_thr_low_alarm(thr_la),
    .i_flag_mask(mask), .i_flag_read(rd), .i_flag_read_chan(rd_chan),
    .i_trip_md_high(tmd_hi), .i_trip_md_low(16'h0000), .i_trip_bias_high(16'hFFFF),
    .i_trip_mask(tmask), .i_fault_clear(fclr), .o_result(result), .o_result_valid(r_valid),
    .o_result_chan(r_chan), .o_flags(flags), .o_alert(alert), .o_trip_flags(trips),
    .o_laser_gate_output(gate), .o_bias_current_output_en(bias_en),
    .o_modulation_current_output_en(mod_en), .o_aux1_format(fmt1), .o_aux2_format(fmt2));
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic burst(input logic [2:0] c, input logic [15:0] d, input logic [4:0] n,
      input logic w);
    @(posedge i_mclk);
    go <= 1'b1;
    s_chan <= c;
    s_data <= d;
    s_cnt <= n;
    @(posedge i_mclk);
    go <= 1'b0;
    if (w) begin
      for (int i = 0; i < 80 && !(r_valid === 1'b1 && r_chan === c); i++) begin
        @(posedge i_mclk);
        #1;
      end
      chk("res_chan", {12'h000, r_valid, r_chan}, {12'h000, 1'b1, c});
      @(posedge i_mclk);
      #1;
    end else begin
      repeat (2 * n + 1) @(posedge i_mclk);
    end
  endtask : burst
  task automatic flag_rd(input logic [2:0] c);
    @(posedge i_mclk);
    rd <= 1'b1;
    rd_chan <= c;
    @(posedge i_mclk);
    rd <= 1'b0;
    #1;
  endtask : flag_rd
  task automatic t_calib;
    logic [15:0] nul;
    burst(3'h1, 16'h1230, 5'h08, 1'b1);
    chk("sup_res", result[1], 16'h1230);
    burst(3'h1, 16'h0100, 5'h08, 1'b1);
    nul = result[1];
    @(posedge i_mclk);
    offset[1] <= -(nul >> 2);
    burst(3'h1, 16'h0100, 5'h08, 1'b1);
    chk("null_res", result[1], 16'h0000);
    @(posedge i_mclk);
    gain[1] <= 16'hFFFF;
    burst(3'h1, 16'hF000, 5'h08, 1'b1);
    chk("sat_res", result[1], 16'hFFF8);
    @(posedge i_mclk);
    gain[1] <= 16'h8000;
    offset[1] <= 16'h0000;
  endtask : t_calib
  task automatic t_gain;
    logic [15:0] g;
    logic [15:0] hi;
    g = 16'h0000;
    for (int n = 15; n >= 0; n--) begin
      g[n] = 1'b1;
      @(posedge i_mclk);
      gain[1] <= g;
      burst(3'h1, 16'h8000, 5'h08, 1'b1);
      hi = result[1];
      burst(3'h1, 16'h0000, 5'h08, 1'b1);
      if (hi >= 16'hFFF8 || hi - result[1] > 16'hE666) begin
        g[n] = 1'b0;
      end
    end
    chk("gain_srch", g, 16'hE666);
    @(posedge i_mclk);
    gain[1] <= 16'h8000;
  endtask : t_gain
  task automatic t_shift;
    @(posedge i_mclk);
    shift[3] <= 4'h3;
    shift[1] <= 4'h3;
    burst(3'h3, 16'h8000, 5'h08, 1'b1);
    chk("rx_shift", result[3], 16'h1000);
    burst(3'h1, 16'h8000, 5'h08, 1'b1);
    chk("sup_noshift", result[1], 16'h8000);
    @(posedge i_mclk);
    shift[3] <= 4'h1;
    gain[3] <= 16'hFFFF;
    gain[0] <= 16'h0000;
    offset[0] <= 16'h0002;
    burst(3'h3, 16'hF000, 5'h08, 1'b1);
    chk("rx_ceil", result[3], 16'h7FFC);
    burst(3'h0, 16'hF600, 5'h10, 1'b1);
    chk("temp_res", result[0], 16'hF608);
    chk("temp_flags", {12'h000, flags[0]}, 16'h0003);
    flag_rd(3'h0);
    @(posedge i_mclk);
    slow <= 1'b1;
    burst(3'h2, 16'h1000, 5'h04, 1'b0);
    burst(3'h2, 16'h3000, 5'h04, 1'b1);
    chk("avg_res", result[2], 16'h2000);
    @(posedge i_mclk);
    slow <= 1'b0;
  endtask : t_shift
  task automatic t_flags;
    @(posedge i_mclk);
    thr_hw[1] <= 16'h1000;
    burst(3'h1, 16'h1230, 5'h08, 1'b1);
    chk("hw_flag", {11'h000, alert, flags[1]}, 16'h0014);
    burst(3'h1, 16'h0800, 5'h08, 1'b1);
    chk("latched", {12'h000, flags[1]}, 16'h0004);
    flag_rd(3'h1);
    chk("cleared", {11'h000, alert, flags[1]}, 16'h0000);
    @(posedge i_mclk);
    mask[1] <= 4'h4;
    thr_la[2] <= 16'h0500;
    thr_hw[6] <= 16'h1000;
    burst(3'h1, 16'h1230, 5'h08, 1'b1);
    chk("masked", {12'h000, flags[1]}, 16'h0000);
    burst(3'h2, 16'h0100, 5'h08, 1'b1);
    chk("la_flag", {11'h000, alert, flags[2]}, 16'h0011);
    flag_rd(3'h2);
    burst(3'h6, 16'h1230, 5'h08, 1'b1);
    chk("md_noalert", {11'h000, alert, flags[6]}, 16'h0004);
  endtask : t_flags
  task automatic t_trip;
    @(posedge i_mclk);
    tmd_hi <= 16'h4000;
    burst(3'h6, 16'h5000, 5'h08, 1'b1);
    chk("trip", {10'h000, gate, bias_en, mod_en, trips}, 16'h0022);
    chk("md_res", result[6], 16'h5000);
    @(posedge i_mclk);
    fclr <= 1'b1;
    tmask <= 3'h2;
    @(posedge i_mclk);
    fclr <= 1'b0;
    #1;
    chk("gate_clr", {12'h000, gate, trips}, 16'h0000);
    burst(3'h6, 16'h5000, 5'h08, 1'b1);
    chk("gate_mask", {14'h0000, gate, bias_en}, 16'h0001);
  endtask : t_trip
  task automatic t_fmt;
    logic [15:0] ex;
    for (int u = 0; u < 16; u++) begin
      @(posedge i_mclk);
      aux_unit <= u[3:0];
      @(posedge i_mclk);
      #1;
      ex = (u == 0) ? 16'h0000 : (u == 4) ? 16'h000A : 16'h0005;
      chk("aux_fmt", {12'h000, fmt1, fmt2}, ex);
    end
    @(posedge i_mclk);
    aux_unit <= 4'h4;
    burst(3'h4, 16'hF600, 5'h08, 1'b1);
    chk("aux_signed", result[4], 16'hF600);
    @(posedge i_mclk);
    aux_unit <= 4'h0;
    burst(3'h5, 16'h1230, 5'h08, 1'b0);
    chk("aux_unused", result[5], 16'h0000);
  endtask : t_fmt
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    gain = {N{16'h8000}};
    offset = '0;
    shift = '0;
    thr_ha = {N{16'hFFFF}};
    thr_hw = {N{16'hFFFF}};
    thr_lw = '0;
    thr_la = '0;
    mask = '0;
    repeat (10) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    #1;
    chk("rst_res", result[1], 16'h0000);
    chk("rst_out", {12'h000, alert, gate, bias_en, mod_en}, 16'h0003);
    t_calib();
    t_gain();
    t_shift();
    t_flags();
    t_trip();
    t_fmt();
    close_out();
  end
endmodule : testbench
